// ### include/aegs_consts.svh
// Offsets, reset values and timing counts of the exposure/gain/strobe block.
`ifndef AEGS_CONSTS_SVH
`define AEGS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing, gain and deadband
// ----------------------------------------------------------------------------
`define AEGS_CLK_NS 25
`define AEGS_TICK_NS 1000
`define AEGS_TICK_CYC (`AEGS_TICK_NS / `AEGS_CLK_NS)
`define AEGS_EXP_MIN_US 16'h0019
`define AEGS_FRAME_US_DEF 16'h411B
`define AEGS_GAIN_TOTAL_DB 6'h30
`define AEGS_GAIN_ANALOG_DB 6'h18
`define AEGS_LUM_DEADBAND 13'h0010

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AEGS_REG_CTRL 8'h00
`define AEGS_REG_EXP_MAN 8'h04
`define AEGS_REG_EXP_MIN 8'h08
`define AEGS_REG_EXP_MAX 8'h0C
`define AEGS_REG_GAIN_MIN 8'h10
`define AEGS_REG_GAIN_MAX 8'h14
`define AEGS_REG_TARGET 8'h18
`define AEGS_REG_GAIN_MAN 8'h1C
`define AEGS_REG_WIN_X 8'h20
`define AEGS_REG_WIN_Y 8'h24
`define AEGS_REG_STROBE0 8'h28
`define AEGS_REG_STROBE1 8'h2C
`define AEGS_REG_STROBE_REF 8'h30
`define AEGS_REG_STATUS 8'h34
`define AEGS_REG_LUM 8'h38
`define AEGS_REG_EXP_CUR 8'h3C
`define AEGS_REG_GAIN_CUR 8'h40

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AEGS_RST_EXP_MAN 16'h1000
`define AEGS_RST_EXP_MAX 16'hFFFF
`define AEGS_RST_TARGET 12'h800
`define AEGS_RST_SPAN 32'hFFFF_0000
`define AEGS_RST_STROBE 32'h000A_0000

`endif

// ### include/aegs_pkg.sv
// Types shared by the exposure/gain/strobe block and its users.
package aegs_pkg;

  // Control register fields, bit 0 is exposure control enable.
  typedef struct packed {
    logic win_en;
    logic locked_en;
    logic [1:0] speed;
    logic metric_max;
    logic ag_en;
    logic ae_en;
    logic exp_ctrl_en;
  } aegs_ctrl_t;

  // One sensor pixel with its position flags.
  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic eof;
    logic [11:0] data;
  } aegs_pix_t;

  // A pair of 16-bit fields: upper half and lower half of a register.
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } aegs_span_t;

  // Loop sequencer states.
  typedef enum logic [1:0] {AEGS_IDLE, AEGS_DIV, AEGS_STEP} aegs_loop_st_t;

endpackage

// ### logic/aegs_ctrl.sv
// Exposure timing, auto exposure/gain loop and two strobe generators.
`timescale 1ns/1ps
`include "aegs_consts.svh"

module aegs_ctrl
  import aegs_pkg::*;
#(
  parameter logic [15:0] FRAME_US = `AEGS_FRAME_US_DEF
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Sensor side.
  input wire aegs_pix_t pix_i,
  output aegs_pix_t pix_o,
  output logic [5:0] analog_gain_o,
  output logic expo_start_o,
  output logic readout_start_o,
  // External sync and strobes.
  input wire logic tri_sync_i,
  output logic [1:0] strobe_o
);

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam logic [5:0] TICK_LAST = 6'(`AEGS_TICK_CYC - 1);
  localparam logic [15:0] EXP_FLOOR = `AEGS_EXP_MIN_US;
  localparam logic [5:0] GAIN_TOP = `AEGS_GAIN_TOTAL_DB;
  localparam logic [5:0] GAIN_ANA = `AEGS_GAIN_ANALOG_DB;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  aegs_ctrl_t ctrl_q;
  logic [15:0] exp_man_q, exp_min_q, exp_max_q;
  logic [5:0] gain_min_q, gain_max_q, gain_man_q;
  logic [11:0] target_q;
  aegs_span_t win_x_q, win_y_q;
  aegs_span_t strb_q [2];
  logic [1:0] strb_ref_q;
  logic [11:0] lum_q;
  logic [15:0] exp_cur_q, loop_exp_q;
  logic [5:0] gain_cur_q, loop_gain_q;
  logic exp_lim_q, glim_hi_q, glim_lo_q;

  // Software writes; each register takes one aligned word.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= '0;
      exp_man_q <= `AEGS_RST_EXP_MAN;
      exp_min_q <= `AEGS_EXP_MIN_US;
      exp_max_q <= `AEGS_RST_EXP_MAX;
      gain_min_q <= '0;
      gain_max_q <= `AEGS_GAIN_TOTAL_DB;
      gain_man_q <= '0;
      target_q <= `AEGS_RST_TARGET;
      win_x_q <= `AEGS_RST_SPAN;
      win_y_q <= `AEGS_RST_SPAN;
      strb_q[0] <= `AEGS_RST_STROBE;
      strb_q[1] <= `AEGS_RST_STROBE;
      strb_ref_q <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `AEGS_REG_CTRL: ctrl_q <= aegs_ctrl_t'(reg_wdata_i[7:0]);
        `AEGS_REG_EXP_MAN: exp_man_q <= reg_wdata_i[15:0];
        `AEGS_REG_EXP_MIN: exp_min_q <= reg_wdata_i[15:0];
        `AEGS_REG_EXP_MAX: exp_max_q <= reg_wdata_i[15:0];
        `AEGS_REG_GAIN_MIN: gain_min_q <= reg_wdata_i[5:0];
        `AEGS_REG_GAIN_MAX: gain_max_q <= reg_wdata_i[5:0];
        `AEGS_REG_TARGET: target_q <= reg_wdata_i[11:0];
        `AEGS_REG_GAIN_MAN: gain_man_q <= reg_wdata_i[5:0];
        `AEGS_REG_WIN_X: win_x_q <= reg_wdata_i;
        `AEGS_REG_WIN_Y: win_y_q <= reg_wdata_i;
        `AEGS_REG_STROBE0: strb_q[0] <= reg_wdata_i;
        `AEGS_REG_STROBE1: strb_q[1] <= reg_wdata_i;
        `AEGS_REG_STROBE_REF: strb_ref_q <= reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      case (reg_addr_i)
        `AEGS_REG_CTRL: reg_rdata_o <= {24'h00_0000, ctrl_q};
        `AEGS_REG_EXP_MAN: reg_rdata_o <= {16'h0000, exp_man_q};
        `AEGS_REG_EXP_MIN: reg_rdata_o <= {16'h0000, exp_min_q};
        `AEGS_REG_EXP_MAX: reg_rdata_o <= {16'h0000, exp_max_q};
        `AEGS_REG_GAIN_MIN: reg_rdata_o <= {26'h000_0000, gain_min_q};
        `AEGS_REG_GAIN_MAX: reg_rdata_o <= {26'h000_0000, gain_max_q};
        `AEGS_REG_TARGET: reg_rdata_o <= {20'h0_0000, target_q};
        `AEGS_REG_GAIN_MAN: reg_rdata_o <= {26'h000_0000, gain_man_q};
        `AEGS_REG_WIN_X: reg_rdata_o <= win_x_q;
        `AEGS_REG_WIN_Y: reg_rdata_o <= win_y_q;
        `AEGS_REG_STROBE0: reg_rdata_o <= strb_q[0];
        `AEGS_REG_STROBE1: reg_rdata_o <= strb_q[1];
        `AEGS_REG_STROBE_REF: reg_rdata_o <= {30'h0000_0000, strb_ref_q};
        `AEGS_REG_STATUS: reg_rdata_o <= {29'h0000_0000, glim_lo_q, glim_hi_q, exp_lim_q};
        `AEGS_REG_LUM: reg_rdata_o <= {20'h0_0000, lum_q};
        `AEGS_REG_EXP_CUR: reg_rdata_o <= {16'h0000, exp_cur_q};
        `AEGS_REG_GAIN_CUR: reg_rdata_o <= {26'h000_0000, gain_cur_q};
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Frame timing
  // --------------------------------------------------------------------------
  logic sync_s1_q, sync_s2_q, sync_s3_q;
  logic [5:0] tick_q;
  logic [15:0] fcnt_q;
  logic us_end, boundary;
  logic [15:0] exp_pos;

  // Two-stage synchroniser for the sync pin, third stage for the edge.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
    end else begin
      sync_s1_q <= tri_sync_i;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end

  // Frame period is FRAME_US unless locked_en restarts it on a sync edge; exposure never touches it.
  assign us_end = (tick_q == TICK_LAST);
  assign boundary = (us_end && fcnt_q == FRAME_US - 16'h0001)
                    || (ctrl_q.locked_en && sync_s2_q && !sync_s3_q);
  assign exp_pos = FRAME_US - exp_cur_q;

  // Microsecond tick and position within the frame.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= '0;
      fcnt_q <= '0;
    end else if (boundary) begin
      tick_q <= '0;
      fcnt_q <= '0;
    end else if (us_end) begin
      tick_q <= '0;
      fcnt_q <= fcnt_q + 16'h0001;
    end else begin
      tick_q <= tick_q + 6'h01;
    end
  end

  // Exposure starts so that it ends at the next readout start.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      readout_start_o <= 1'b0;
      expo_start_o <= 1'b0;
    end else begin
      readout_start_o <= boundary;
      expo_start_o <= (tick_q == 6'h00) && (fcnt_q == exp_pos);
    end
  end

  // --------------------------------------------------------------------------
  // Settings applied at the frame boundary
  // --------------------------------------------------------------------------
  logic [15:0] eff_min, eff_max, exp_sel;
  logic [5:0] gain_sel;

  // Clamp limits: floor of 25 us, ceiling of one frame.
  assign eff_min = (exp_min_q < EXP_FLOOR) ? EXP_FLOOR : exp_min_q;
  assign eff_max = (exp_max_q > FRAME_US) ? FRAME_US : exp_max_q;

  // Select the exposure and gain for the next frame.
  always_comb begin
    if (!ctrl_q.exp_ctrl_en) begin
      exp_sel = FRAME_US;
    end else if (ctrl_q.ae_en) begin
      exp_sel = loop_exp_q;
    end else if (exp_man_q < EXP_FLOOR) begin
      exp_sel = EXP_FLOOR;
    end else if (exp_man_q > FRAME_US) begin
      exp_sel = FRAME_US;
    end else begin
      exp_sel = exp_man_q;
    end
    if (ctrl_q.ag_en) begin
      gain_sel = loop_gain_q;
    end else begin
      gain_sel = (gain_man_q > GAIN_TOP) ? GAIN_TOP : gain_man_q;
    end
  end

  // New values take effect only when a frame starts.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exp_cur_q <= FRAME_US;
      gain_cur_q <= '0;
    end else if (boundary) begin
      exp_cur_q <= exp_sel;
      gain_cur_q <= gain_sel;
    end
  end

  // --------------------------------------------------------------------------
  // Luminance measurement
  // --------------------------------------------------------------------------
  logic [15:0] x_q, y_q, cur_x, cur_y;
  logic [32:0] sum_q;
  logic [20:0] cnt_q;
  logic [11:0] max_q;
  logic in_win, frame_done_q;

  // Pixel coordinates from the row and frame flags.
  assign cur_x = (pix_i.sof || pix_i.sol) ? 16'h0000 : x_q + 16'h0001;
  assign cur_y = pix_i.sof ? 16'h0000 : (pix_i.sol ? y_q + 16'h0001 : y_q);
  assign in_win = !ctrl_q.win_en
                  || (cur_x >= win_x_q.lo && cur_x <= win_x_q.hi
                      && cur_y >= win_y_q.lo && cur_y <= win_y_q.hi);

  // Accumulate sum, count and peak over the in_win pixels of one frame.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_q <= '0;
      y_q <= '0;
      sum_q <= '0;
      cnt_q <= '0;
      max_q <= '0;
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= pix_i.valid && pix_i.eof;
      if (pix_i.valid) begin
        x_q <= cur_x;
        y_q <= cur_y;
        if (pix_i.sof) begin
          sum_q <= in_win ? {21'h00_0000, pix_i.data} : '0;
          cnt_q <= in_win ? 21'h00_0001 : '0;
          max_q <= in_win ? pix_i.data : '0;
        end else if (in_win) begin
          sum_q <= sum_q + {21'h00_0000, pix_i.data};
          cnt_q <= cnt_q + 21'h00_0001;
          max_q <= (pix_i.data > max_q) ? pix_i.data : max_q;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Auto exposure / gain loop
  // --------------------------------------------------------------------------
  aegs_loop_st_t st_q;
  logic [3:0] div_i_q;
  logic [32:0] rem_q, trial;
  logic [11:0] quo_q, snap_max_q, lum_new, err_abs, step_raw;
  logic [20:0] snap_cnt_q;
  logic dark, bright;
  logic [15:0] estep;
  logic [5:0] gstep;
  logic [6:0] g_up, g_dn;

  // Restoring division for the mean, one quotient bit per cycle.
  assign trial = {12'h000, snap_cnt_q} << div_i_q;
  assign lum_new = ctrl_q.metric_max ? snap_max_q
                   : ((snap_cnt_q == 21'h00_0000) ? 12'h000 : quo_q);
  assign dark = ({1'b0, lum_new} + `AEGS_LUM_DEADBAND) < {1'b0, target_q};
  assign bright = {1'b0, lum_new} > ({1'b0, target_q} + `AEGS_LUM_DEADBAND);
  assign err_abs = dark ? target_q - lum_new : lum_new - target_q;
  // Larger speed code means smaller steps and slower settling.
  assign step_raw = err_abs >> ctrl_q.speed;
  assign estep = (step_raw == 12'h000) ? 16'h0001 : {4'h0, step_raw};
  assign gstep = (step_raw[11:7] == 5'h00) ? 6'h01 : {1'b0, step_raw[11:7]};
  // Gain sums one bit wider, so a large step near the top cannot wrap.
  assign g_up = {1'b0, loop_gain_q} + {1'b0, gstep};
  assign g_dn = {1'b0, gain_min_q} + {1'b0, gstep};

  // Sequencer: snapshot at frame end, divide, then take one step.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= AEGS_IDLE;
      div_i_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
      snap_cnt_q <= '0;
      snap_max_q <= '0;
      lum_q <= '0;
    end else begin
      unique case (st_q)
        AEGS_IDLE: begin
          if (frame_done_q) begin
            rem_q <= sum_q;
            snap_cnt_q <= cnt_q;
            snap_max_q <= max_q;
            quo_q <= '0;
            div_i_q <= 4'hB;
            st_q <= AEGS_DIV;
          end
        end
        AEGS_DIV: begin
          if (rem_q >= trial) begin
            rem_q <= rem_q - trial;
            quo_q[div_i_q] <= 1'b1;
          end
          div_i_q <= div_i_q - 4'h1;
          if (div_i_q == 4'h0) begin
            st_q <= AEGS_STEP;
          end
        end
        AEGS_STEP: begin
          lum_q <= lum_new;
          st_q <= AEGS_IDLE;
        end
      endcase
    end
  end

  // Exposure first when dark; at its maximum, gain takes over. When bright, gain falls first, then exposure.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_exp_q <= FRAME_US;
      loop_gain_q <= '0;
      exp_lim_q <= 1'b0;
      glim_hi_q <= 1'b0;
      glim_lo_q <= 1'b0;
    end else if (st_q == AEGS_STEP && ctrl_q.ae_en) begin
      if (dark) begin
        glim_lo_q <= 1'b0;
        if (loop_exp_q + estep >= eff_max) begin
          loop_exp_q <= eff_max;
          exp_lim_q <= 1'b1;
          if (ctrl_q.ag_en) begin
            loop_gain_q <= (g_up >= {1'b0, gain_max_q}) ? gain_max_q
                           : g_up[5:0];
            glim_hi_q <= (g_up >= {1'b0, gain_max_q});
          end
        end else begin
          loop_exp_q <= loop_exp_q + estep;
          exp_lim_q <= 1'b0;
        end
      end else if (bright) begin
        glim_hi_q <= 1'b0;
        if (ctrl_q.ag_en && loop_gain_q > gain_min_q) begin
          loop_gain_q <= ({1'b0, loop_gain_q} <= g_dn) ? gain_min_q
                         : loop_gain_q - gstep;
        end else begin
          loop_exp_q <= (loop_exp_q <= eff_min + estep) ? eff_min
                        : loop_exp_q - estep;
          exp_lim_q <= 1'b0;
        end
      end
    end else if (st_q == AEGS_STEP && ctrl_q.ag_en) begin
      if (dark) begin
        glim_lo_q <= 1'b0;
        loop_gain_q <= (g_up >= {1'b0, gain_max_q}) ? gain_max_q
                       : g_up[5:0];
        glim_hi_q <= (g_up >= {1'b0, gain_max_q});
      end else if (bright) begin
        glim_hi_q <= 1'b0;
        loop_gain_q <= ({1'b0, loop_gain_q} <= g_dn) ? gain_min_q
                       : loop_gain_q - gstep;
        glim_lo_q <= ({1'b0, loop_gain_q} <= g_dn);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Gain split: analog first, digital beyond
  // --------------------------------------------------------------------------
  logic [4:0] dg_idx;
  logic [12:0] dg_mult;
  logic [24:0] prod;

  // Digital multiplier, 8 fractional bits, one entry per dB.
  function automatic logic [12:0] db_mult(input logic [4:0] db);
    case (db)
      5'h01: db_mult = 13'h011F;
      5'h02: db_mult = 13'h0142;
      5'h03: db_mult = 13'h016A;
      5'h04: db_mult = 13'h0196;
      5'h05: db_mult = 13'h01C7;
      5'h06: db_mult = 13'h01FF;
      5'h07: db_mult = 13'h023D;
      5'h08: db_mult = 13'h0283;
      5'h09: db_mult = 13'h02D2;
      5'h0A: db_mult = 13'h032A;
      5'h0B: db_mult = 13'h038D;
      5'h0C: db_mult = 13'h03FB;
      5'h0D: db_mult = 13'h0478;
      5'h0E: db_mult = 13'h0503;
      5'h0F: db_mult = 13'h05A0;
      5'h10: db_mult = 13'h0650;
      5'h11: db_mult = 13'h0715;
      5'h12: db_mult = 13'h07F3;
      5'h13: db_mult = 13'h08EB;
      5'h14: db_mult = 13'h0A00;
      5'h15: db_mult = 13'h0B39;
      5'h16: db_mult = 13'h0C98;
      5'h17: db_mult = 13'h0E21;
      5'h18: db_mult = 13'h0FDB;
      default: db_mult = 13'h0100;
    endcase
  endfunction

  assign dg_idx = (gain_cur_q > GAIN_ANA) ? 5'(gain_cur_q - GAIN_ANA) : 5'h00;
  assign dg_mult = db_mult(dg_idx);
  assign prod = {13'h0000, pix_i.data} * {12'h000, dg_mult};

  // Analog part to the sensor, digital part on each pixel.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_gain_o <= '0;
      pix_o <= '0;
    end else begin
      analog_gain_o <= (gain_cur_q > GAIN_ANA) ? GAIN_ANA : gain_cur_q;
      pix_o.valid <= pix_i.valid;
      pix_o.sof <= pix_i.sof;
      pix_o.sol <= pix_i.sol;
      pix_o.eof <= pix_i.eof;
      pix_o.data <= (prod[24:20] != 5'h00) ? 12'hFFF : prod[19:8];
    end
  end

  // --------------------------------------------------------------------------
  // Strobes
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_strobe
    logic [16:0] pos_sum;
    logic [15:0] ref_pos, pos, elapsed, width;

    // Reference is readout start, or exposure start when selected.
    assign ref_pos = (strb_ref_q[i] && ctrl_q.exp_ctrl_en) ? exp_pos : 16'h0000;
    assign pos_sum = {1'b0, ref_pos} + {1'b0, strb_q[i].lo};
    assign pos = (pos_sum >= {1'b0, FRAME_US}) ? 16'(pos_sum - {1'b0, FRAME_US})
                 : pos_sum[15:0];
    assign elapsed = (fcnt_q >= pos) ? fcnt_q - pos : fcnt_q + FRAME_US - pos;
    assign width = (strb_q[i].hi == 16'h0000) ? 16'h0001
                   : ((strb_q[i].hi > FRAME_US) ? FRAME_US : strb_q[i].hi);

    // Each strobe is high for its width after its own position.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        strobe_o[i] <= 1'b0;
      end else begin
        strobe_o[i] <= (elapsed < width);
      end
    end
  end

endmodule

// ### verification/aegs_ctrl_chk.sv
// Port checker for the exposure/gain/strobe block.
`timescale 1ns/1ps
module aegs_ctrl_chk
  import aegs_pkg::*;
#(
  parameter logic [15:0] FRAME_US = 16'h0032
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Watched ports.
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire aegs_pix_t pix_i,
  input wire aegs_pix_t pix_o,
  input wire logic [5:0] analog_gain_o,
  input wire logic expo_start_o,
  input wire logic readout_start_o,
  input wire logic [1:0] strobe_o
);
  localparam int PER = int'(FRAME_US) * 40;
  logic [31:0] cyc_q;
  logic [31:0] hi_q;
  logic seen_q;
  logic [1:0] wr_age_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Counts cycles since the last readout start; seen marks a complete reference.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_q <= '0;
      seen_q <= 1'b0;
    end else begin
      cyc_q <= readout_start_o ? 32'h0000_0000 : cyc_q + 1;
      seen_q <= seen_q | readout_start_o;
    end
  end
  // Counts how long strobe 1 has been high; a write may cut a pulse for two frames.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_q <= '0;
      wr_age_q <= 2'h0;
    end else begin
      hi_q <= strobe_o[1] ? hi_q + 1 : 32'h0000_0000;
      wr_age_q <= reg_wr_i ? 2'h2 : wr_age_q - 2'((readout_start_o && wr_age_q != 2'h0));
    end
  end
  frame_period_a: assert property (readout_start_o && seen_q |-> cyc_q == PER - 1)
    else $error("frame period wrong");
  expo_pulse_a: assert property (expo_start_o |=> !expo_start_o)
    else $error("exposure start longer than one cycle");
  expo_grid_a: assert property (expo_start_o && seen_q |-> cyc_q % 40 == 0 && cyc_q <= PER - 1000)
    else $error("exposure start off grid or too late");
  strobe_step_a: assert property ($fell(strobe_o[1]) && seen_q && wr_age_q == 2'h0 |-> hi_q % 40 == 0)
    else $error("strobe width not whole microseconds");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");
  pix_delay_a: assert property (pix_o[15:12] == $past(pix_i[15:12]))
    else $error("pixel flags not delayed by one");
  pix_gain_a: assert property (pix_o.valid |-> pix_o.data >= $past(pix_i.data))
    else $error("pixel value reduced");
  analog_cap_a: assert property (analog_gain_o <= 6'h18)
    else $error("analog gain above cap");
  gain_frame_a: assert property ($changed(analog_gain_o) |-> readout_start_o ||
    $past(readout_start_o) || $past(readout_start_o, 2)) else $error("gain changed mid frame");
endmodule

bind aegs_ctrl aegs_ctrl_chk #(.FRAME_US(FRAME_US)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pix_i(pix_i), .pix_o(pix_o),
  .analog_gain_o(analog_gain_o), .expo_start_o(expo_start_o),
  .readout_start_o(readout_start_o), .strobe_o(strobe_o));

// ### verification/aegs_sensor_model.sv
// Sensor readout model: a small frame of pixels after each readout start.
`timescale 1ns/1ps
module aegs_sensor_model
  import aegs_pkg::*;
#(
  parameter int COLS = 8,
  parameter int NPIX = 32
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Frame trigger and scene level.
  input wire logic readout_i,
  input wire logic [11:0] level_i,
  // Pixels towards the block.
  output aegs_pix_t pix_o
);
  int n_q;
  // Rows of 12-bit pixels ramping one code a column; idle data toggles so none is stale.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      n_q <= NPIX;
      pix_o <= '0;
    end else if (n_q < NPIX) begin
      n_q <= readout_i ? 0 : n_q + 1;
      pix_o <= {1'b1, n_q == 0, n_q % COLS == 0 && n_q != 0, n_q == NPIX - 1,
        level_i + 12'(n_q % COLS)};
    end else begin
      n_q <= readout_i ? 0 : n_q;
      pix_o <= {4'h0, ~pix_o.data};
    end
  end
endmodule

// ### verification/aegs_ctrl_tb.sv
// Self-checking bench for the exposure/gain/strobe block.
`timescale 1ns/1ps
`include "aegs_consts.svh"
module aegs_ctrl_tb
  import aegs_pkg::*;
;
  localparam logic [15:0] FR = 16'h0032;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] level = 12'h010;
  logic [31:0] rdata;
  aegs_pix_t pix;
  logic [5:0] again;
  logic ro;
  logic [1:0] strobe;
  logic [15:0] v;
  logic [15:0] w;
  int t0;
  int t1;
  int p;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] lc[4] = '{8'h00, 8'h08, 8'h88, 8'h80};
  logic [31:0] lx[4] = '{32'hFFFF_0000, 32'hFFFF_0000, 32'h0000_0000, 32'h0078_0064};
  logic [11:0] lo[4] = '{12'h003, 12'h007, 12'h000, 12'h000};

  aegs_ctrl #(.FRAME_US(FR)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pix_i(pix),
    .pix_o(), .analog_gain_o(again), .expo_start_o(), .readout_start_o(ro),
    .tri_sync_i(1'b0), .strobe_o(strobe));
  aegs_sensor_model u_sensor (.clock_i(clock_i), .rst_n_i(rst_n_i), .readout_i(ro),
    .level_i(level), .pix_o(pix));

  // Clock of 25 ns.
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  function automatic logic [15:0] exp_of(input logic [15:0] m);
    return (m < `AEGS_EXP_MIN_US) ? `AEGS_EXP_MIN_US : (m > FR) ? FR : m;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(posedge clock_i);
    chk(rdata, e);
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge clock_i iff ro === 1'b1);
    repeat (100) @(posedge clock_i);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    #(25 * 100000);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h923c9b01));
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wr_reg(`AEGS_REG_LUM, 32'h0000_0ABC);
    rd_chk(`AEGS_REG_LUM, 32'h0000_0000);
    rd_chk(`AEGS_REG_EXP_CUR, {16'h0000, FR});
    rd_chk(`AEGS_REG_STROBE0, `AEGS_RST_STROBE);
    rd_chk(8'hFC, 32'h0000_0000);
    $display("test reset done");
    wr_reg(`AEGS_REG_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'h0005 : (i == 1) ? 16'hFFFF : 16'($urandom_range(49, 25));
      wr_reg(`AEGS_REG_EXP_MAN, {16'h0000, v});
      frames(2);
      rd_chk(`AEGS_REG_EXP_CUR, {16'h0000, exp_of(v)});
    end
    wr_reg(`AEGS_REG_CTRL, 32'h0000_0000);
    frames(2);
    rd_chk(`AEGS_REG_EXP_CUR, {16'h0000, FR});
    $display("test exposure done");
    level <= 12'($urandom_range(12'h7F0, 12'h020));
    for (int i = 0; i < 4; i++) begin
      wr_reg(`AEGS_REG_WIN_X, lx[i]);
      wr_reg(`AEGS_REG_CTRL, {24'h0, lc[i]});
      frames(2);
      rd_chk(`AEGS_REG_LUM, {20'h0, (i == 3) ? 12'h000 : level + lo[i]});
    end
    $display("test luminance done");
    level <= 12'h010;
    wr_reg(`AEGS_REG_GAIN_MAX, 32'h0000_0005);
    wr_reg(`AEGS_REG_CTRL, 32'h0000_0004);
    frames(4);
    rd_chk(`AEGS_REG_GAIN_CUR, 32'h0000_0005);
    rd_chk(`AEGS_REG_STATUS, 32'h0000_0002);
    chk({26'h0, again}, 32'h0000_0005);
    wr_reg(`AEGS_REG_EXP_MAX, 32'h0000_0028);
    wr_reg(`AEGS_REG_GAIN_MAX, 32'h0000_001E);
    wr_reg(`AEGS_REG_CTRL, 32'h0000_0007);
    frames(6);
    rd_chk(`AEGS_REG_EXP_CUR, 32'h0000_0028);
    rd_chk(`AEGS_REG_GAIN_CUR, 32'h0000_001E);
    rd_chk(`AEGS_REG_STATUS, 32'h0000_0003);
    chk({26'h0, again}, 32'h0000_0018);
    $display("test loops done");
    for (int i = 0; i < 2; i++) begin
      v = 16'($urandom_range(10));
      w = i ? 16'($urandom_range(20, 1)) : 16'h0000;
      wr_reg(`AEGS_REG_STROBE_REF, {30'h0, i[0], 1'b0});
      wr_reg(`AEGS_REG_STROBE1, {w, v});
      frames(2);
      @(posedge clock_i iff ro === 1'b1);
      for (t0 = 0; strobe[1] !== 1'b1 && t0 < 4000; t0++) @(posedge clock_i);
      for (t1 = 0; strobe[1] === 1'b1 && t1 < 4000; t1++) @(posedge clock_i);
      p = (i ? int'(FR) - 40 + int'(v) : int'(v)) * 40;
      chk(32'(t0 - p + 1) <= 32'd3, 32'd1);
      chk(32'(t1), (w == 16'h0000 ? 32'd1 : 32'(w)) * 40);
    end
    $display("test strobe done");
    tally_and_finish();
  end
endmodule
